// file: rtl/rdf_pkg.sv
// Purpose: constants and types for the descriptor field handling block
// Assumes: 16-bit descriptor words, system clock core_clk at 200 MHz
// Notes: descriptor words travel as packed structs
// Contract
// - top four bits of rx word three read back as zero
// - device writes unsigned frame length; host trusts it when no error and end
// - length counts all header, data and crc bytes unless stripping removes pad and crc
// - each tx ring entry is four words read from host memory
// - upper eight bits of tx word one form the status byte
// - host sets holder bit after filling; device clears after sending
// - summary error is or of underflow, late collision, carrier loss, retry failure
// - error flag set in whichever descriptor is current at the error
// - per frame fcs bit forces fcs; when clear the global disable decides
// - per frame fcs bit honoured only with start of packet; never rewritten
// - multiple retry flag set when more than one retry was needed
// - single retry flag set when exactly one retry was needed
// - single retry flag invalid when late collision is set
// - end of packet marks last rx buffer; both start and end mean one buffer
// - skip tx descriptors without start of packet until holder and start set
package rdf_pkg;
   localparam int RDF_WORD_W = 16;
   localparam int RDF_CNT_W = 12;
   localparam int RDF_TX_WORDS = 4;
   localparam int RDF_OWN_BIT = 15;
   localparam int RDF_ERR_BIT = 14;
   localparam int RDF_FCS_BIT = 13;
   localparam int RDF_MORE_BIT = 12;
   localparam int RDF_ONE_BIT = 11;
   localparam int RDF_STP_BIT = 9;
   localparam int RDF_ENP_BIT = 8;
   localparam logic [3:0] RDF_RSV_VAL = 4'h0;
   localparam logic [15:0] RDF_WORD_RST = 16'h0000;
   localparam logic [1:0] RDF_WORD1_IDX = 2'h1;
   localparam int RDF_WORD_STEP = 2;
   localparam int RDF_W1_OFS = 2;
   localparam int RDF_RX3_OFS = 6;

   // tx word one layout
   typedef struct packed {
      logic own;
      logic err;
      logic per_frame_fcs_bit;
      logic more;
      logic one;
      logic def;
      logic start_of_packet_bit;
      logic end_of_packet_bit;
      logic [7:0] hadr;
   } rdf_tx_word_one_t;

   // rx word three layout
   typedef struct packed {
      logic [3:0] rsv;
      logic [11:0] received_length_field;
   } rdf_rx_word_three_t;

   // transmit outcome reported by the mac
   typedef struct packed {
      logic underflow_flag;
      logic late_collision_flag;
      logic carrier_loss_flag;
      logic retry_failure_flag;
      logic [4:0] retries;
   } rdf_tx_result_t;
endpackage : rdf_pkg

// file: rtl/rdf_tx_status.sv
// Purpose: builds the tx status byte from a transmit outcome
// Assumes: inputs stable while used
// Notes: pure combinational helper
`timescale 1ns/10ps
module rdf_tx_status
   import rdf_pkg::*;
(
   // inputs
   input wire rdf_tx_word_one_t word_in,
   input wire rdf_tx_result_t res,
   input wire logic is_err_point,
   // output
   output rdf_tx_word_one_t word_out
);
   ////////////////////////////////////////////////////////////////////////
   // status merge; host fields kept as read
   always_comb
   begin
      word_out = word_in;
      word_out.err = is_err_point & (res.underflow_flag | res.late_collision_flag |
                                     res.carrier_loss_flag | res.retry_failure_flag);
      word_out.more = res.retries > 5'h01;
      // exactly one, masked by late collision
      word_out.one = (res.retries == 5'h01) & ~res.late_collision_flag;
      word_out.own = 1'b0;
   end
endmodule : rdf_tx_status

// file: rtl/rdf_fields.sv
// Purpose: descriptor field handling for tx ring head and rx length word
// Assumes: simple word memory port, one word per request, ack ends it
// Notes: tx fetches four words, returns word one with status
`timescale 1ns/10ps
module rdf_fields
   import rdf_pkg::*;
#(
   parameter int ADDR_W = 24
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // memory port
   output logic mem_req,
   output logic mem_we,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ack,
   // tx control
   input wire logic tx_poll,
   input wire logic [ADDR_W-1:0] tx_desc_addr,
   input wire logic global_tx_fcs_disable,
   input wire logic tx_done,
   input wire logic tx_error,
   input wire rdf_tx_result_t tx_result,
   output logic tx_start,
   output logic tx_fcs_en,
   output logic tx_skip,
   output logic tx_idle,
   // rx control
   input wire logic rx_wr,
   input wire logic [ADDR_W-1:0] rx_desc_addr,
   input wire logic [11:0] rx_frame_bytes,
   input wire logic [11:0] rx_strip_bytes,
   input wire logic rx_auto_strip,
   output logic rx_done
);
   typedef enum logic [2:0] {S_IDLE, S_READ, S_WAIT, S_WRITE, S_RXW} rdf_state_t;

   // sequencer state and word index within the entry
   rdf_state_t state_reg, state_next;
   logic [1:0] idx_reg, idx_next;
   // word one as fetched; status is merged in only on write back
   rdf_tx_word_one_t w1_reg, w1_next, w1_out;
   // next values of the registered outputs
   logic mem_req_next, mem_we_next;
   logic [ADDR_W-1:0] mem_addr_next;
   logic [15:0] mem_wdata_next;
   logic tx_start_next, tx_fcs_next, tx_skip_next, idle_next, rx_done_next;
   // error seen for the descriptor now in use
   logic err_seen_reg, err_seen_next;
   // rx length word as it will be written
   rdf_rx_word_three_t rx_w;

   ////////////////////////////////////////////////////////////////////////
   // status word build
   rdf_tx_status u_stat (
      .word_in(w1_reg),
      .res(tx_result),
      .is_err_point(err_seen_reg | tx_error),
      .word_out(w1_out)
   );

   always_comb
   begin
      rx_w.rsv = RDF_RSV_VAL;
      rx_w.received_length_field = rx_auto_strip ? rx_frame_bytes - rx_strip_bytes : rx_frame_bytes;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      state_next = state_reg;
      idx_next = idx_reg;
      w1_next = w1_reg;
      mem_req_next = 1'b0;
      mem_we_next = 1'b0;
      mem_addr_next = mem_addr;
      mem_wdata_next = mem_wdata;
      tx_start_next = 1'b0;
      tx_skip_next = 1'b0;
      tx_fcs_next = tx_fcs_en;
      idle_next = 1'b0;
      rx_done_next = 1'b0;
      err_seen_next = err_seen_reg;
      case (state_reg)
         S_IDLE:
         begin
            idle_next = 1'b1;
            // rx write wins over a tx fetch raised in the same cycle
            if (rx_wr)
            begin
               // only the length word is written here; flags are the mac's
               mem_req_next = 1'b1;
               mem_we_next = 1'b1;
               mem_addr_next = rx_desc_addr + ADDR_W'(RDF_RX3_OFS);
               mem_wdata_next = rx_w;
               idle_next = 1'b0;
               state_next = S_RXW;
            end
            else if (tx_poll)
            begin
               idx_next = 2'h0;
               mem_req_next = 1'b1;
               mem_addr_next = tx_desc_addr;
               idle_next = 1'b0;
               err_seen_next = 1'b0;
               state_next = S_READ;
            end
         end
         S_READ:
         begin
            // request drops at the ack edge unless another word follows
            mem_req_next = ~mem_ack;
            if (mem_ack)
            begin
               if (idx_reg == RDF_WORD1_IDX)
                  w1_next = mem_rdata;
               if (idx_reg == 2'(RDF_TX_WORDS - 1))
               begin
                  // all four words in, so word one can be judged
                  // skip unless held and start
                  if (w1_reg.own && w1_reg.start_of_packet_bit)
                  begin
                     tx_start_next = 1'b1;
                     tx_fcs_next = w1_reg.per_frame_fcs_bit | ~global_tx_fcs_disable;
                     state_next = S_WAIT;
                  end
                  else
                  begin
                     tx_skip_next = 1'b1;
                     state_next = S_IDLE;
                  end
               end
               else
               begin
                  // step to the next word of the entry
                  idx_next = idx_reg + 2'h1;
                  mem_req_next = 1'b1;
                  mem_addr_next = mem_addr + ADDR_W'(RDF_WORD_STEP);
               end
            end
         end
         S_WAIT:
         begin
            // frame on the wire; the mac ends it with done or error
            // error marks current descriptor
            if (tx_error)
               err_seen_next = 1'b1;
            if (tx_done | tx_error)
            begin
               // single write carries status and holder together
               mem_req_next = 1'b1;
               mem_we_next = 1'b1;
               mem_addr_next = tx_desc_addr + ADDR_W'(RDF_W1_OFS);
               mem_wdata_next = w1_out;
               state_next = S_WRITE;
            end
         end
         S_WRITE, S_RXW:
         begin
            // one write each, held until its ack and dropped after it
            mem_req_next = ~mem_ack;
            mem_we_next = ~mem_ack;
            if (mem_ack)
            begin
               rx_done_next = state_reg == S_RXW;
               state_next = S_IDLE;
            end
         end
         // unused codes fall back to idle
         default:
            state_next = S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   // reset leaves the block quiet; tx_idle rises one edge after release
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= S_IDLE;
         idx_reg <= 2'h0;
         w1_reg <= RDF_WORD_RST;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= '0;
         mem_wdata <= RDF_WORD_RST;
         tx_start <= 1'b0;
         tx_fcs_en <= 1'b0;
         tx_skip <= 1'b0;
         tx_idle <= 1'b0;
         rx_done <= 1'b0;
         err_seen_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         w1_reg <= w1_next;
         mem_req <= mem_req_next;
         mem_we <= mem_we_next;
         mem_addr <= mem_addr_next;
         mem_wdata <= mem_wdata_next;
         tx_start <= tx_start_next;
         tx_fcs_en <= tx_fcs_next;
         tx_skip <= tx_skip_next;
         tx_idle <= idle_next;
         rx_done <= rx_done_next;
         err_seen_reg <= err_seen_next;
      end
   end
endmodule : rdf_fields

// file: test/rdf_fields_checker.sv
// Purpose: port checks for the descriptor field block
// Assumes: bench holds tx_result and rx inputs until the job ends
// Notes: bound to rdf_fields below
`timescale 1ns/10ps
module rdf_fields_checker
   import rdf_pkg::*;
#(
   parameter int ADDR_W = 24
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // memory port
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_ack,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   // tx side
   input wire logic tx_poll,
   input wire logic [ADDR_W-1:0] tx_desc_addr,
   input wire logic global_tx_fcs_disable,
   input wire rdf_tx_result_t tx_result,
   input wire logic tx_start,
   input wire logic tx_fcs_en,
   input wire logic tx_skip,
   input wire logic tx_idle,
   // rx side
   input wire logic rx_wr,
   input wire logic [ADDR_W-1:0] rx_desc_addr,
   input wire logic [11:0] rx_frame_bytes,
   input wire logic [11:0] rx_strip_bytes,
   input wire logic rx_auto_strip,
   input wire logic rx_done
);
   rdf_tx_word_one_t w1_reg;
   logic tx_st;
   logic rx_st;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // write cycles to the status word and the rx length word
   assign tx_st = mem_req && mem_we && mem_addr == tx_desc_addr + ADDR_W'(2);
   assign rx_st = mem_req && mem_we && mem_addr == rx_desc_addr + ADDR_W'(6);
   // word one as fetched, so start and fcs can be judged later
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         w1_reg <= RDF_WORD_RST;
      else if (mem_ack && !mem_we && mem_addr == tx_desc_addr + ADDR_W'(2))
         w1_reg <= mem_rdata;
   sequence s_rx_end; rx_st && mem_ack; endsequence
   property p_fetch; tx_poll && tx_idle && !rx_wr |=> mem_req && !mem_we; endproperty
   property p_rsv; rx_st |-> mem_wdata[15:12] == 4'h0; endproperty
   property p_len; rx_st |-> mem_wdata[11:0] ==
      (rx_auto_strip ? rx_frame_bytes - rx_strip_bytes : rx_frame_bytes); endproperty
   property p_own; tx_st |-> !mem_wdata[15]; endproperty
   property p_err; tx_st |-> mem_wdata[14] == |tx_result[8:5]; endproperty
   property p_retry; tx_st |-> mem_wdata[12:11] == {tx_result.retries > 5'h1,
      tx_result.retries == 5'h1 && !tx_result.late_collision_flag}; endproperty
   property p_keep; tx_st |-> mem_wdata[13] == w1_reg.per_frame_fcs_bit; endproperty
   property p_go; tx_start |-> w1_reg.own && w1_reg.start_of_packet_bit &&
      tx_fcs_en == (w1_reg.per_frame_fcs_bit || !global_tx_fcs_disable); endproperty
   property p_skip; tx_skip |-> !(w1_reg.own && w1_reg.start_of_packet_bit); endproperty
   property p_rx_done; s_rx_end |=> rx_done; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch not started");
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   a_len: assert property (p_len) else $error("rx length wrong");
   a_own: assert property (p_own) else $error("holder not returned");
   a_err: assert property (p_err) else $error("summary error wrong");
   a_retry: assert property (p_retry) else $error("retry flags wrong");
   a_keep: assert property (p_keep) else $error("fcs bit rewritten");
   a_go: assert property (p_go) else $error("bad start or fcs");
   a_skip: assert property (p_skip) else $error("bad skip");
   a_rx_done: assert property (p_rx_done) else $error("rx done missing");
endmodule : rdf_fields_checker
bind rdf_fields rdf_fields_checker #(.ADDR_W(ADDR_W)) rdf_fields_checker_i (.core_clk, .rst,
   .mem_req, .mem_we, .mem_ack, .tx_poll, .tx_start, .tx_fcs_en, .tx_skip, .tx_idle, .rx_wr,
   .rx_auto_strip, .rx_done, .global_tx_fcs_disable, .mem_addr, .tx_desc_addr, .rx_desc_addr,
   .mem_wdata, .mem_rdata, .rx_frame_bytes, .rx_strip_bytes, .tx_result);

// file: test/rdf_host_mem.sv
// Purpose: host memory holding the descriptor words
// Assumes: word index from address bits 4:1
// Notes: lat sets the ack delay; idle read data toggles
`timescale 1ns/10ps
module rdf_host_mem
(
   // memory port
   input wire logic core_clk,
   input wire logic rst,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [23:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [1:0] lat,
   output logic [15:0] mem_rdata,
   output logic mem_ack
);
   logic [15:0] mem [16];
   logic [1:0] wait_reg;
   // words change only by the host or a device write
   always @(posedge core_clk or posedge rst)
      if (rst)
      begin
         mem_ack <= 1'b0;
         wait_reg <= 2'h0;
         mem_rdata <= 16'h5a5a;
      end
      else
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack && wait_reg != lat)
            wait_reg <= wait_reg + 2'h1;
         else if (mem_req && !mem_ack)
         begin
            mem_ack <= 1'b1;
            wait_reg <= 2'h0;
            if (mem_we)
               mem[mem_addr[4:1]] <= mem_wdata;
            else
               mem_rdata <= mem[mem_addr[4:1]];
         end
      end
endmodule : rdf_host_mem

// file: test/rdf_fields_tb_top.sv
// Purpose: random and corner tests of the descriptor field block
// Assumes: tx descriptor at byte 0, rx descriptor at byte 16
// Notes: expected tx word comes from a bench function; rx word is built inline
`timescale 1ns/10ps
module rdf_fields_tb_top import rdf_pkg::*; ;
   logic core_clk, rst, mem_req, mem_we, mem_ack, tx_poll, global_tx_fcs_disable, tx_done;
   logic tx_error, tx_start, tx_fcs_en, tx_skip, tx_idle, rx_wr, rx_auto_strip, rx_done;
   logic [23:0] mem_addr;
   logic [15:0] mem_wdata, mem_rdata, w;
   logic [11:0] rx_frame_bytes, rx_strip_bytes;
   logic [1:0] lat;
   logic [31:0] r;
   rdf_tx_result_t tx_result;
   int num_errors, samples_checked;
   rdf_fields rdf_fields_i (.core_clk, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .mem_rdata, .mem_ack, .tx_poll, .tx_desc_addr(24'h000000), .global_tx_fcs_disable,
      .tx_done, .tx_error, .tx_result, .tx_start, .tx_fcs_en, .tx_skip, .tx_idle, .rx_wr,
      .rx_desc_addr(24'h000010), .rx_frame_bytes, .rx_strip_bytes, .rx_auto_strip, .rx_done);
   rdf_host_mem rdf_host_mem_i (.core_clk, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .lat, .mem_rdata, .mem_ack);
   always #2.5 core_clk = ~core_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   // word one after a sent frame, holder returned
   function automatic logic [15:0] tx_exp(input logic [15:0] d, input rdf_tx_result_t t);
      return {1'b0, |t[8:5], d[13], t.retries > 5'h1,
         t.retries == 5'h1 && !t.late_collision_flag, d[10:0]};
   endfunction : tx_exp
   task automatic stop_test;
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (!ok)
      begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   // bounded wait: 0 start or skip, 1 idle, 2 rx done
   task automatic wait_for(input int s);
      int n;
      n = 0;
      while (n < 100 && !(s == 0 ? (tx_start | tx_skip) === 1'b1 :
         s == 1 ? tx_idle === 1'b1 : rx_done === 1'b1))
      begin
         @(negedge core_clk);
         n++;
      end
      if (n == 100)
      begin
         num_errors++;
         stop_test;
      end
   endtask : wait_for
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {core_clk, tx_poll, tx_done, tx_error, rx_wr, global_tx_fcs_disable} = 6'h00;
      {rst, rx_auto_strip, lat, tx_result, rx_frame_bytes, rx_strip_bytes} = 37'h1000000000;
      r = 32'hf1a7;
      num_errors = 0;
      samples_checked = 0;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      for (int i = 0; i < 40; i++)
      begin
         r = lfsr(r);
         wait_for(1);
         // first two entries lack holder or start, entry two has late_collision_flag with one retry
         w = {i != 0, r[14:10], i != 1 && (r[20] || i < 8), r[8:0]};
         tx_result = i == 2 ? 9'h081 : {r[24:21] & {4{r[25]}}, 2'h0, r[28:26]};
         rdf_host_mem_i.mem[1] = w;
         global_tx_fcs_disable = r[29];
         lat = r[31:30];
         tx_poll = 1'b1;
         @(negedge core_clk);
         tx_poll = 1'b0;
         wait_for(0);
         chk(tx_start === (w[15] & w[9]), "start or skip wrong");
         if (tx_start === 1'b1)
         begin
            chk(tx_fcs_en === (w[13] | !global_tx_fcs_disable), "fcs enable wrong");
            tx_error = |tx_result[8:5];
            tx_done = !tx_error;
            @(negedge core_clk);
            {tx_done, tx_error} = 2'h0;
            wait_for(1);
            w = tx_exp(w, tx_result) ^ rdf_host_mem_i.mem[1];
            chk((w & 16'hfbff) === 16'h0000, "word one wrong");
         end
         else
            chk(rdf_host_mem_i.mem[1] === w, "skipped entry changed");
         wait_for(1);
         rdf_host_mem_i.mem[10] = ~r[15:0];
         rdf_host_mem_i.mem[11] = 16'hffff;
         {rx_auto_strip, rx_frame_bytes, rx_strip_bytes} = {r[4], r[11:0], r[23:12] & r[11:0]};
         rx_wr = 1'b1;
         @(negedge core_clk);
         rx_wr = 1'b0;
         wait_for(2);
         w = {4'h0, rx_auto_strip ? rx_frame_bytes - rx_strip_bytes : rx_frame_bytes};
         chk(rdf_host_mem_i.mem[11] === w, "rx length wrong");
         chk(rdf_host_mem_i.mem[10] === ~r[15:0], "buffer size changed");
      end
      stop_test;
   end
endmodule : rdf_fields_tb_top
